// *** rtl/i2te_pkg.sv ***
// Purpose: Shared constants and types for the audio port task/event block
// Assumes: 32-bit AHB-Lite words, one register per aligned word
// Notes:   Offsets are byte addresses within the block's 4 KB window
package i2te_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_START     = 12'h000;
    localparam logic [11:0] OFF_STOP      = 12'h004;
    localparam logic [11:0] OFF_SUB_START = 12'h080;
    localparam logic [11:0] OFF_SUB_STOP  = 12'h084;
    localparam logic [11:0] OFF_EV_RX     = 12'h104;
    localparam logic [11:0] OFF_EV_HALT   = 12'h108;
    localparam logic [11:0] OFF_EV_TX     = 12'h114;
    localparam logic [11:0] OFF_EV_FRAME  = 12'h11C;
    localparam logic [11:0] OFF_PUB_RX    = 12'h184;
    localparam logic [11:0] OFF_PUB_HALT  = 12'h188;
    localparam logic [11:0] OFF_PUB_TX    = 12'h194;
    localparam logic [11:0] OFF_PUB_FRAME = 12'h19C;
    localparam logic [11:0] OFF_INT_EN    = 12'h300;
    localparam logic [11:0] OFF_INT_SET   = 12'h304;
    localparam logic [11:0] OFF_INT_CLR   = 12'h308;
    localparam logic [11:0] OFF_INT_STAT  = 12'h310;
    localparam logic [11:0] OFF_EV_CLR    = 12'h314;
    localparam logic [11:0] OFF_STATE     = 12'h318;
    localparam logic [11:0] OFF_RX_EN     = 12'h508;
    localparam logic [11:0] OFF_TX_EN     = 12'h50C;
    localparam logic [11:0] OFF_MCK_EN    = 12'h510;
    localparam logic [11:0] OFF_RX_PTR    = 12'h538;
    localparam logic [11:0] OFF_TX_PTR    = 12'h540;
    localparam logic [11:0] OFF_WCOUNT    = 12'h550;

    // Field positions
    localparam int unsigned TASK_BIT      = 0;
    localparam int unsigned FLAG_BIT      = 0;
    localparam int unsigned CFG_EN_BIT    = 31;
    localparam int unsigned CHAN_W        = 8;
    localparam int unsigned CHAN_N        = 256;
    localparam int unsigned INT_RX_BIT    = 1;
    localparam int unsigned INT_HALT_BIT  = 2;
    localparam int unsigned INT_TX_BIT    = 5;
    localparam int unsigned INT_FRAME_BIT = 7;
    localparam int unsigned WCOUNT_W      = 16;

    // Reset values
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;
    localparam logic [15:0] RST_COUNT  = 16'h0000;
    localparam logic        RST_BIT    = 1'b0;

    typedef struct packed {
        logic              en;
        logic [CHAN_W-1:0] idx;
    } i2te_chan_cfg_t;

    typedef struct packed {
        logic frame;
        logic tx;
        logic halt;
        logic rx;
    } i2te_evt_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_HALT = 3'b100
    } i2te_state_t;

endpackage

// *** rtl/i2te_core.sv ***
// Purpose: Task, event, channel routing and interrupt front end of an
//          audio serial port, reached over AHB-Lite
// Assumes: Serial engine on hclk; word-select pin asynchronous to hclk
// Notes:   Reads take one wait state, writes none; response always OKAY
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module i2te_core (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Event interconnect
    input  wire logic [255:0] channel_events,
    output logic      [255:0] channel_publish,
    // Serial engine
    input  wire logic        rx_word_done,
    input  wire logic        tx_word_done,
    input  wire logic        engine_halted,
    input  wire logic        word_select_clock,
    output logic             transfer_run,
    output logic             master_clock_run,
    output logic             rx_pointer_taken,
    output logic             tx_pointer_taken,
    output logic      [31:0] rx_active_pointer,
    output logic      [31:0] tx_active_pointer,
    // Interrupt
    output logic             irq
);

    function automatic i2te_pkg::i2te_chan_cfg_t cfg_from(
        input logic [31:0] w);
        cfg_from.en  = w[i2te_pkg::CFG_EN_BIT];
        cfg_from.idx = w[i2te_pkg::CHAN_W-1:0];
    endfunction

    function automatic logic [31:0] cfg_word(
        input i2te_pkg::i2te_chan_cfg_t c);
        cfg_word = {c.en, 23'h00_0000, c.idx};
    endfunction

    function automatic logic chan_hit(input i2te_pkg::i2te_chan_cfg_t c,
                                      input logic [255:0] ch);
        chan_hit = c.en & ch[c.idx];
    endfunction

    function automatic logic [255:0] route(
        input i2te_pkg::i2te_chan_cfg_t c, input logic ev);
        route = 256'h0;
        route[c.idx] = c.en & ev;
    endfunction

    function automatic logic [31:0] evt_word(input i2te_pkg::i2te_evt_t e);
        evt_word = i2te_pkg::RST_WORD;
        evt_word[i2te_pkg::INT_RX_BIT]    = e.rx;
        evt_word[i2te_pkg::INT_HALT_BIT]  = e.halt;
        evt_word[i2te_pkg::INT_TX_BIT]    = e.tx;
        evt_word[i2te_pkg::INT_FRAME_BIT] = e.frame;
    endfunction

    function automatic i2te_pkg::i2te_evt_t evt_from(input logic [31:0] w);
        evt_from.rx    = w[i2te_pkg::INT_RX_BIT];
        evt_from.halt  = w[i2te_pkg::INT_HALT_BIT];
        evt_from.tx    = w[i2te_pkg::INT_TX_BIT];
        evt_from.frame = w[i2te_pkg::INT_FRAME_BIT];
    endfunction

    // Count reaches limit; a zero limit behaves as one word
    function automatic logic count_done(input logic [15:0] cnt,
                                        input logic [15:0] lim);
        count_done = ({1'b0, cnt} + 17'h0_0001) >= {1'b0, lim};
    endfunction

    // Bus state
    logic        wr_pend_reg;
    logic        rd_pend_reg;
    logic [11:0] addr_q_reg;
    logic [31:0] hrdata_reg;
    logic        hready_reg;
    logic        hresp_reg;
    // Configuration
    i2te_pkg::i2te_chan_cfg_t sub_start_reg, sub_stop_reg;
    i2te_pkg::i2te_chan_cfg_t pub_rx_reg, pub_halt_reg;
    i2te_pkg::i2te_chan_cfg_t pub_tx_reg, pub_frame_reg;
    i2te_pkg::i2te_evt_t      flags_reg, interrupt_enable_mask_reg;
    logic        rx_en_reg;
    logic        tx_en_reg;
    logic        mck_en_reg;
    logic [31:0] rx_ptr_reg;
    logic [31:0] tx_ptr_reg;
    logic [15:0] wcount_reg;
    // Transfer state
    i2te_pkg::i2te_state_t state_reg, state_next;
    logic [15:0]  rx_cnt_reg;
    logic [15:0]  tx_cnt_reg;
    logic [31:0]  rx_act_reg;
    logic [31:0]  tx_act_reg;
    logic         rx_take_reg;
    logic         tx_take_reg;
    logic         run_reg;
    logic         mck_reg;
    logic         irq_reg;
    logic [255:0] publish_reg;
    logic [2:0]   ws_sync_reg;
    logic         ws_level_reg;

    // Address and write decode
    wire addr_ok  = hsel & htrans[1] & hready;
    wire wr_start = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_START;
    wire wr_stop  = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_STOP;
    wire wr_subs  = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_SUB_START;
    wire wr_subp  = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_SUB_STOP;
    wire wr_evrx  = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_EV_RX;
    wire wr_evh   = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_EV_HALT;
    wire wr_evtx  = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_EV_TX;
    wire wr_evf   = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_EV_FRAME;
    wire wr_purx  = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_PUB_RX;
    wire wr_puh   = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_PUB_HALT;
    wire wr_putx  = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_PUB_TX;
    wire wr_puf   = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_PUB_FRAME;
    wire wr_ien   = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_INT_EN;
    wire wr_iset  = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_INT_SET;
    wire wr_iclr  = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_INT_CLR;
    wire wr_evclr = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_EV_CLR;
    wire wr_rxen  = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_RX_EN;
    wire wr_txen  = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_TX_EN;
    wire wr_mcken = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_MCK_EN;
    wire wr_rxptr = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_RX_PTR;
    wire wr_txptr = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_TX_PTR;
    wire wr_wcnt  = wr_pend_reg && addr_q_reg == i2te_pkg::OFF_WCOUNT;
    wire wbit     = hwdata[i2te_pkg::TASK_BIT];

    // Task triggers from software or a subscribed channel
    wire start_req = (wr_start & wbit)
                   | chan_hit(sub_start_reg, channel_events);
    wire stop_req  = (wr_stop & wbit)
                   | chan_hit(sub_stop_reg, channel_events);
    // Stop wins over a simultaneous start
    wire start_go  = (state_reg == i2te_pkg::ST_IDLE) & start_req
                   & ~stop_req;

    // Word counting toward buffer size
    wire running  = state_reg == i2te_pkg::ST_RUN;
    wire rx_step  = running & rx_en_reg & rx_word_done;
    wire tx_step  = running & tx_en_reg & tx_word_done;
    wire rx_take  = rx_step & count_done(rx_cnt_reg, wcount_reg);
    wire tx_take  = tx_step & count_done(tx_cnt_reg, wcount_reg);

    // Word-select edge: falling edge marks a new frame
    wire ws_agree = ws_sync_reg[1] == ws_sync_reg[2];
    wire ws_fall  = ws_agree & ~ws_sync_reg[2] & ws_level_reg;
    wire frame_ev = ws_fall & running;
    wire halt_ev  = (state_reg == i2te_pkg::ST_HALT)
                  & engine_halted;

    i2te_pkg::i2te_evt_t raised, clr, flags_next, interrupt_enable_mask_next;
    assign raised.rx    = rx_take;
    assign raised.halt  = halt_ev;
    assign raised.tx    = tx_take;
    assign raised.frame = frame_ev;

    // Writing 0 to an event register, or 1 to the clear word, clears it
    wire [31:0] clr_w = wr_evclr ? hwdata : i2te_pkg::RST_WORD;
    assign clr.rx    = (wr_evrx & ~hwdata[i2te_pkg::FLAG_BIT])
                     | clr_w[i2te_pkg::INT_RX_BIT];
    assign clr.halt  = (wr_evh & ~hwdata[i2te_pkg::FLAG_BIT])
                     | clr_w[i2te_pkg::INT_HALT_BIT];
    assign clr.tx    = (wr_evtx & ~hwdata[i2te_pkg::FLAG_BIT])
                     | clr_w[i2te_pkg::INT_TX_BIT];
    assign clr.frame = (wr_evf & ~hwdata[i2te_pkg::FLAG_BIT])
                     | clr_w[i2te_pkg::INT_FRAME_BIT];

    // New events beat a same-cycle clear
    assign flags_next = (flags_reg & ~clr) | raised;

    wire [3:0] wr_mask = evt_from(hwdata);
    assign interrupt_enable_mask_next = wr_ien  ? wr_mask :
                        wr_iset ? interrupt_enable_mask_reg | wr_mask :
                        wr_iclr ? interrupt_enable_mask_reg & ~wr_mask :
                        interrupt_enable_mask_reg;

    wire [255:0] publish_next = route(pub_rx_reg, rx_take)
                              | route(pub_halt_reg, halt_ev)
                              | route(pub_tx_reg, tx_take)
                              | route(pub_frame_reg, frame_ev);

    // Engine is expected to report halted quickly; a start during halt is
    // ignored so the halt-done event of the pending stop is never lost
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            i2te_pkg::ST_IDLE: begin
                if (stop_req) begin
                    state_next = i2te_pkg::ST_HALT;
                end else if (start_req) begin
                    state_next = i2te_pkg::ST_RUN;
                end
            end
            i2te_pkg::ST_RUN: begin
                if (stop_req) begin
                    state_next = i2te_pkg::ST_HALT;
                end
            end
            i2te_pkg::ST_HALT: begin
                if (engine_halted) begin
                    state_next = i2te_pkg::ST_IDLE;
                end
            end
            default: state_next = i2te_pkg::ST_IDLE;
        endcase
    end

    // Read selection
    logic [31:0] rd_mux;
    always_comb begin
        case (addr_q_reg)
            i2te_pkg::OFF_SUB_START: rd_mux = cfg_word(sub_start_reg);
            i2te_pkg::OFF_SUB_STOP:  rd_mux = cfg_word(sub_stop_reg);
            i2te_pkg::OFF_EV_RX:     rd_mux = {31'h0, flags_reg.rx};
            i2te_pkg::OFF_EV_HALT:   rd_mux = {31'h0, flags_reg.halt};
            i2te_pkg::OFF_EV_TX:     rd_mux = {31'h0, flags_reg.tx};
            i2te_pkg::OFF_EV_FRAME:  rd_mux = {31'h0, flags_reg.frame};
            i2te_pkg::OFF_PUB_RX:    rd_mux = cfg_word(pub_rx_reg);
            i2te_pkg::OFF_PUB_HALT:  rd_mux = cfg_word(pub_halt_reg);
            i2te_pkg::OFF_PUB_TX:    rd_mux = cfg_word(pub_tx_reg);
            i2te_pkg::OFF_PUB_FRAME: rd_mux = cfg_word(pub_frame_reg);
            i2te_pkg::OFF_INT_EN,
            i2te_pkg::OFF_INT_SET,
            i2te_pkg::OFF_INT_CLR:   rd_mux = evt_word(interrupt_enable_mask_reg);
            i2te_pkg::OFF_INT_STAT:  rd_mux = evt_word(flags_reg);
            i2te_pkg::OFF_STATE:     rd_mux = {29'h0, mck_reg,
                                               state_reg == i2te_pkg::ST_HALT,
                                               running};
            i2te_pkg::OFF_RX_EN:     rd_mux = {31'h0, rx_en_reg};
            i2te_pkg::OFF_TX_EN:     rd_mux = {31'h0, tx_en_reg};
            i2te_pkg::OFF_MCK_EN:    rd_mux = {31'h0, mck_en_reg};
            i2te_pkg::OFF_RX_PTR:    rd_mux = rx_ptr_reg;
            i2te_pkg::OFF_TX_PTR:    rd_mux = tx_ptr_reg;
            i2te_pkg::OFF_WCOUNT:    rd_mux = {16'h0000, wcount_reg};
            default:                 rd_mux = i2te_pkg::RST_WORD;
        endcase
    end

    // Bus pipeline; a read waits one cycle so hrdata comes from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_q_reg  <= 12'h000;
            hrdata_reg  <= i2te_pkg::RST_WORD;
            hready_reg  <= 1'b1;
            hresp_reg   <= 1'b0;
        end else begin
            wr_pend_reg <= addr_ok & hwrite;
            rd_pend_reg <= addr_ok & ~hwrite;
            hready_reg  <= ~(addr_ok & ~hwrite);
            hresp_reg   <= 1'b0;
            if (addr_ok) begin
                addr_q_reg <= haddr[11:0];
            end
            if (rd_pend_reg) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    // Software configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_start_reg <= '0;
            sub_stop_reg  <= '0;
            pub_rx_reg    <= '0;
            pub_halt_reg  <= '0;
            pub_tx_reg    <= '0;
            pub_frame_reg <= '0;
            rx_en_reg     <= i2te_pkg::RST_BIT;
            tx_en_reg     <= i2te_pkg::RST_BIT;
            mck_en_reg    <= i2te_pkg::RST_BIT;
            rx_ptr_reg    <= i2te_pkg::RST_WORD;
            tx_ptr_reg    <= i2te_pkg::RST_WORD;
            wcount_reg    <= i2te_pkg::RST_COUNT;
        end else begin
            if (wr_subs)  sub_start_reg <= cfg_from(hwdata);
            if (wr_subp)  sub_stop_reg  <= cfg_from(hwdata);
            if (wr_purx)  pub_rx_reg    <= cfg_from(hwdata);
            if (wr_puh)   pub_halt_reg  <= cfg_from(hwdata);
            if (wr_putx)  pub_tx_reg    <= cfg_from(hwdata);
            if (wr_puf)   pub_frame_reg <= cfg_from(hwdata);
            if (wr_rxen)  rx_en_reg     <= wbit;
            if (wr_txen)  tx_en_reg     <= wbit;
            if (wr_mcken) mck_en_reg    <= wbit;
            if (wr_rxptr) rx_ptr_reg    <= hwdata;
            if (wr_txptr) tx_ptr_reg    <= hwdata;
            if (wr_wcnt)  wcount_reg    <= hwdata[i2te_pkg::WCOUNT_W-1:0];
        end
    end

    // Word-select synchroniser; only the settled level is looked at
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ws_sync_reg  <= 3'h0;
            ws_level_reg <= 1'b0;
        end else begin
            ws_sync_reg <= {ws_sync_reg[1:0], word_select_clock};
            if (ws_agree) begin
                ws_level_reg <= ws_sync_reg[2];
            end
        end
    end

    // Transfer control, pointer buffers and counts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg   <= i2te_pkg::ST_IDLE;
            run_reg     <= 1'b0;
            mck_reg     <= 1'b0;
            rx_cnt_reg  <= i2te_pkg::RST_COUNT;
            tx_cnt_reg  <= i2te_pkg::RST_COUNT;
            rx_act_reg  <= i2te_pkg::RST_WORD;
            tx_act_reg  <= i2te_pkg::RST_WORD;
            rx_take_reg <= 1'b0;
            tx_take_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            run_reg     <= state_next == i2te_pkg::ST_RUN;
            rx_take_reg <= rx_take;
            tx_take_reg <= tx_take;
            if (start_go) begin
                mck_reg <= mck_en_reg;
            end else if (stop_req) begin
                mck_reg <= 1'b0;
            end
            if (start_go) begin
                rx_cnt_reg <= i2te_pkg::RST_COUNT;
                rx_act_reg <= rx_ptr_reg;
            end else if (rx_take) begin
                rx_cnt_reg <= i2te_pkg::RST_COUNT;
                rx_act_reg <= rx_ptr_reg;
            end else if (rx_step) begin
                rx_cnt_reg <= rx_cnt_reg + 16'h0001;
            end
            if (start_go) begin
                tx_cnt_reg <= i2te_pkg::RST_COUNT;
                tx_act_reg <= tx_ptr_reg;
            end else if (tx_take) begin
                tx_cnt_reg <= i2te_pkg::RST_COUNT;
                tx_act_reg <= tx_ptr_reg;
            end else if (tx_step) begin
                tx_cnt_reg <= tx_cnt_reg + 16'h0001;
            end
        end
    end

    // Event flags, enables, publication and interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_reg   <= '0;
            interrupt_enable_mask_reg   <= '0;
            publish_reg <= 256'h0;
            irq_reg     <= 1'b0;
        end else begin
            flags_reg   <= flags_next;
            interrupt_enable_mask_reg   <= interrupt_enable_mask_next;
            publish_reg <= publish_next;
            irq_reg     <= |(flags_next & interrupt_enable_mask_next);
        end
    end

    assign hrdata            = hrdata_reg;
    assign hreadyout         = hready_reg;
    assign hresp             = hresp_reg;
    assign channel_publish   = publish_reg;
    assign transfer_run      = run_reg;
    assign master_clock_run  = mck_reg;
    assign rx_pointer_taken  = rx_take_reg;
    assign tx_pointer_taken  = tx_take_reg;
    assign rx_active_pointer = rx_act_reg;
    assign tx_active_pointer = tx_act_reg;
    assign irq               = irq_reg;

endmodule // i2te_core

`default_nettype wire

// *** bench/i2te_props.sv ***
// Purpose: Port assertions for i2te_core
// Assumes: One clock domain, hresetn asynchronous and active low
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module i2te_props (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    // Block outputs
    input wire logic        transfer_run,
    input wire logic        master_clock_run,
    input wire logic        rx_pointer_taken,
    input wire logic        tx_pointer_taken,
    input wire logic        irq
);
    logic        wr_reg;
    logic [11:0] adr_reg;
    wire         wr_end = wr_reg && hready;
    wire         stop_w = wr_end && adr_reg == i2te_pkg::OFF_STOP
                          && hwdata[0];
    wire         mask_0 = wr_end && adr_reg == i2te_pkg::OFF_INT_EN
                          && hwdata == 32'h0000_0000;
    // Writes finish at the first data phase edge, no wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_reg  <= 1'b0;
            adr_reg <= 12'h000;
        end else if (hready) begin
            wr_reg  <= hsel && htrans[1] && hwrite;
            adr_reg <= haddr[11:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_stop_halts: assert property (stop_w |=>
        !transfer_run && !master_clock_run) else $error("Stop ignored");
    a_mck_in_run: assert property (
        master_clock_run |-> transfer_run) else $error("Clock without run");
    a_rx_once: assert property (
        rx_pointer_taken |=> !rx_pointer_taken) else $error("Rx take long");
    a_tx_once: assert property (
        tx_pointer_taken |=> !tx_pointer_taken) else $error("Tx take long");
    a_rx_in_run: assert property (
        rx_pointer_taken |-> $past(transfer_run)) else $error("Rx idle take");
    a_tx_in_run: assert property (
        tx_pointer_taken |-> $past(transfer_run)) else $error("Tx idle take");
    a_irq_masked: assert property (mask_0 |-> ##2 !irq)
        else $error("Irq with all enables off");
    a_read_wait: assert property (!hreadyout |=> hreadyout)
        else $error("Wait state too long");
endmodule // i2te_props
bind i2te_core i2te_props u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .transfer_run(transfer_run),
    .master_clock_run(master_clock_run), .irq(irq),
    .rx_pointer_taken(rx_pointer_taken), .tx_pointer_taken(tx_pointer_taken)
);
`default_nettype wire

// *** bench/i2te_engine_model.sv ***
// Purpose: Serial engine and codec stand-in
// Assumes: Word select of 160 ns period, only while running
// Notes:   Halt is reported a few cycles late, like a real engine
`timescale 1ns/1ps
`default_nettype none
module i2te_engine_model (
    // Clock and control
    input  wire logic hclk,
    input  wire logic run,
    // Engine status
    output logic      rx_word_done,
    output logic      tx_word_done,
    output logic      engine_halted,
    output logic      word_select_clock
);
    logic       ws_q = 1'b0;
    logic [2:0] run_d = 3'b000;
    initial begin
        word_select_clock = 1'b0;
        #37;
        // Clock stands still outside transfers
        forever #80 if (run) word_select_clock = ~word_select_clock;
    end
    always @(posedge hclk) begin
        ws_q <= word_select_clock;
        rx_word_done <= run && (word_select_clock != ws_q);
        tx_word_done <= run && (word_select_clock != ws_q);
        run_d <= {run_d[1:0], run};
        engine_halted <= ~|run_d;
    end
endmodule // i2te_engine_model
`default_nettype wire

// *** bench/tb_i2s_task_event_control.sv ***
// Purpose: Register level tests of i2te_core
// Assumes: Single AHB-Lite slave, hready tied to hreadyout
// Notes:   Engine model answers for the serial side
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_i2s_task_event_control;
    logic         hclk = 1'b0;
    logic         hresetn = 1'b0;
    logic [31:0]  haddr = 32'h0000_0000;
    logic [1:0]   htrans = 2'b00;
    logic         hwrite = 1'b0;
    logic [31:0]  hwdata = 32'h0000_0000;
    logic [255:0] chev = 256'h0;
    logic [31:0]  q;
    wire  [31:0]  hrdata, rxp, txp;
    wire  [255:0] pub;
    wire          hrdy, hresp, rxw_d, txw_d, halted, ws, run, master_clock_output;
    wire          rxt, txt, irq;
    int           fail_count = 0, n_compared = 0, cyc = 0, i;
    int           rxw = 0, fpub = 0, hpub = 0;
    logic [11:0]  ra [5] = '{i2te_pkg::OFF_SUB_START, i2te_pkg::OFF_EV_TX,
        i2te_pkg::OFF_PUB_FRAME, i2te_pkg::OFF_INT_EN, 12'h3F0};
    logic [11:0]  ca [11] = '{i2te_pkg::OFF_SUB_START, i2te_pkg::OFF_PUB_RX,
        i2te_pkg::OFF_PUB_HALT, i2te_pkg::OFF_PUB_TX, i2te_pkg::OFF_PUB_FRAME,
        i2te_pkg::OFF_RX_EN, i2te_pkg::OFF_TX_EN, i2te_pkg::OFF_MCK_EN,
        i2te_pkg::OFF_WCOUNT, i2te_pkg::OFF_RX_PTR, i2te_pkg::OFF_TX_PTR};
    logic [31:0]  cv [11] = '{32'h8000_0005, 32'h8000_0010, 32'h8000_0011,
        32'h8000_0012, 32'h8000_00FF, 32'h1, 32'h1, 32'h1, 32'h2,
        32'h2000_0000, 32'h3000_0000};
    logic [11:0]  ea [4] = '{i2te_pkg::OFF_EV_RX, i2te_pkg::OFF_EV_HALT,
        i2te_pkg::OFF_EV_TX, i2te_pkg::OFF_EV_FRAME};
    i2te_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
        .hresp(hresp), .channel_events(chev), .channel_publish(pub),
        .rx_word_done(rxw_d), .tx_word_done(txw_d), .engine_halted(halted),
        .word_select_clock(ws), .transfer_run(run), .master_clock_run(master_clock_output),
        .rx_pointer_taken(rxt), .tx_pointer_taken(txt),
        .rx_active_pointer(rxp), .tx_active_pointer(txp), .irq(irq));
    i2te_engine_model u_eng (.hclk(hclk), .run(run), .rx_word_done(rxw_d),
        .tx_word_done(txw_d), .engine_halted(halted), .word_select_clock(ws));
    task automatic close_out;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic xfer(input logic [11:0] a, logic w, logic [31:0] d);
        htrans <= 2'b10;
        haddr <= {20'h0_0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hrdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    task automatic pulse(input int c);
        chev <= 256'h1 << c;
        @(posedge hclk);
        chev <= 256'h0;
        @(posedge hclk);
    endtask
    task automatic halt_wait;
        q = 32'h0;
        for (i = 0; i < 30 && q !== 32'h1; i++)
            xfer(i2te_pkg::OFF_EV_HALT, 0, 0);
    endtask
    always #5 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (rxw_d === 1'b1 && run === 1'b1) rxw++;
        if (pub[255] === 1'b1) fpub++;
        if (pub[17] === 1'b1) hpub++;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(12'h3F0, 1, 32'hFFFF_FFFF);
        foreach (ra[k]) begin
            xfer(ra[k], 0, 0);
            `CHK("reset word", 32'h0, q)
        end
        // Upper bits written as ones read back zero
        for (i = 0; i < 11; i++)
            xfer(ca[i], 1, cv[i] | (i < 5 ? 32'h7FFF_FF00 : 0));
        for (i = 0; i < 5; i++) begin
            xfer(ca[i], 0, 0);
            `CHK("channel cfg", cv[i], q)
        end
        xfer(i2te_pkg::OFF_INT_SET, 1, 32'h86);
        xfer(i2te_pkg::OFF_INT_SET, 1, 32'h20);
        xfer(i2te_pkg::OFF_INT_EN, 0, 0);
        `CHK("mask set", 32'hA6, q)
        xfer(i2te_pkg::OFF_INT_CLR, 1, 32'h4);
        xfer(i2te_pkg::OFF_INT_SET, 0, 0);
        `CHK("mask clear", 32'hA2, q)
        pulse(6);
        `CHK("other channel", 1'b0, run)
        pulse(5);
        `CHK("sub start", 1'b1, run & master_clock_output)
        for (i = 9; i < 11; i++)
            xfer(ca[i], 1, cv[i] + 32'h40);
        for (i = 0; i < 400 && rxt !== 1'b1; i++) @(posedge hclk);
        `CHK("rx words", 2, rxw)
        `CHK("rx pointer", 32'h2000_0040, rxp)
        `CHK("rx route", 1'b1, pub[16] & irq)
        for (i = 0; i < 400 && txt !== 1'b1; i++) @(posedge hclk);
        `CHK("tx pointer", 32'h3000_0040, txp)
        `CHK("tx route", 1'b1, pub[18])
        repeat (40) @(posedge hclk);
        `CHK("frame route", 1'b1, fpub > 0)
        xfer(i2te_pkg::OFF_EV_FRAME, 0, 0);
        `CHK("frame flag", 32'h1, q)
        xfer(i2te_pkg::OFF_INT_EN, 1, 32'h0);
        repeat (2) @(posedge hclk);
        `CHK("irq masked", 1'b0, irq)
        xfer(i2te_pkg::OFF_STOP, 1, 32'h1);
        @(posedge hclk);
        `CHK("stopped", 1'b0, run | master_clock_output)
        halt_wait();
        `CHK("halt flag", 32'h1, q)
        for (i = 0; i < 4; i++) begin
            xfer(ea[i], 1, 0);
            xfer(ea[i], 0, 0);
            `CHK("flag clear", 32'h0, q)
        end
        xfer(i2te_pkg::OFF_STOP, 1, 32'h1);
        halt_wait();
        `CHK("idle stop", 2, hpub)
        xfer(i2te_pkg::OFF_START, 1, 32'h1);
        @(posedge hclk);
        `CHK("start task", 1'b1, run)
        xfer(i2te_pkg::OFF_SUB_STOP, 1, 32'h8000_0007);
        pulse(7);
        `CHK("sub stop", 1'b0, run)
        close_out();
    end
endmodule // tb_i2s_task_event_control
`default_nettype wire
